// >>> hw/lacr_cfg.svh
// Register map, field positions, reset values and fixed counts of the regulator
`ifndef LACR_CFG_SVH
`define LACR_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define LACR_ADDR_CONFIG 8'h00
`define LACR_ADDR_VEL_LOW 8'h04
`define LACR_ADDR_VEL_HIGH 8'h08
`define LACR_ADDR_STATUS 8'h0c
`define LACR_ADDR_IRQ_STAT 8'h10
`define LACR_ADDR_IRQ_MASK 8'h14

// ==========================================================================
// Configuration register fields
`define LACR_LOWER_LSB 0
`define LACR_UPPER_LSB 4
`define LACR_INC_LSB 8
`define LACR_DEC_LSB 10
`define LACR_MIN_BIT 12
`define LACR_FILT_BIT 13
`define LACR_RUN_LSB 16
`define LACR_CONFIG_MASK 32'h001f_3fff
`define LACR_RST_CONFIG 32'h001f_0000
`define LACR_RST_SCALE 5'h1f

// ==========================================================================
// Status and interrupt fields
`define LACR_ST_SCALE_LSB 0
`define LACR_ST_STALL_BIT 5
`define LACR_ST_ACTIVE_BIT 6
`define LACR_ST_LOAD_LSB 16
`define LACR_IRQ_RAISE 0
`define LACR_IRQ_LOWER 1
`define LACR_IRQ_STALL 2
`define LACR_RST_IRQ 3'h0

// ==========================================================================
// Fixed counts
`define LACR_THRESH_ZEROS 5'h00
`define LACR_FILTER_LAST 2'h3
`define LACR_DEC_COUNT_0 6'h20
`define LACR_DEC_COUNT_1 6'h08
`define LACR_DEC_COUNT_2 6'h02
`define LACR_DEC_COUNT_3 6'h01

`endif

// >>> hw/lacr_pkg.sv
// Types shared by the load-adaptive current regulator
package lacr_pkg;
	typedef logic [4:0] lacr_scale_t;
	typedef logic [9:0] lacr_load_t;
	typedef enum logic [1:0] {
		lacr_inc_1,
		lacr_inc_2,
		lacr_inc_4,
		lacr_inc_8
	} lacr_inc_code_t;
	typedef enum logic [1:0] {
		lacr_dec_per_32,
		lacr_dec_per_8,
		lacr_dec_per_2,
		lacr_dec_per_1
	} lacr_dec_code_t;
endpackage

// >>> hw/lacr_load_filter.sv
// Optional four-reading average of the load measurement
`timescale 1ns/1ns
`default_nettype none
`include "lacr_cfg.svh"

module lacr_load_filter (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_filter_enable,
	input wire logic i_valid,
	input wire lacr_pkg::lacr_load_t i_load,
	output logic o_valid,
	output lacr_pkg::lacr_load_t o_load
);
	logic [1:0] cnt_reg;
	logic [11:0] sum_reg;
	logic [11:0] sum_all;

	assign sum_all = sum_reg + {2'h0, i_load};

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_reg <= 2'h0;
			sum_reg <= 12'h000;
		end else if (!i_filter_enable) begin
			cnt_reg <= 2'h0;
			sum_reg <= 12'h000;
		end else if (i_valid) begin
			if (cnt_reg == `LACR_FILTER_LAST) begin
				cnt_reg <= 2'h0;
				sum_reg <= 12'h000;
			end else begin
				cnt_reg <= cnt_reg + 2'h1;
				sum_reg <= sum_all;
			end
		end
	end

	// One result per reading, or per fourth reading when averaging
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_valid <= 1'b0;
			o_load <= 10'h000;
		end else begin
			o_valid <= i_valid && (!i_filter_enable ||
				cnt_reg == `LACR_FILTER_LAST);
			if (i_valid)
				o_load <= i_filter_enable ? sum_all[11:2] : i_load;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	property p_filter_rate;
		i_filter_enable && i_valid && cnt_reg != `LACR_FILTER_LAST |=> !o_valid;
	endproperty
	a_filter_rate: assert property (p_filter_rate)
		else $error("averaging filter released a result early");

	property p_pass_through;
		!i_filter_enable && i_valid |=> o_valid && o_load == $past(i_load);
	endproperty
	a_pass_through: assert property (p_pass_through)
		else $error("unfiltered reading not passed on next cycle");
endmodule
`default_nettype wire

// >>> hw/lacr_velocity_gate.sv
// Window of step periods inside which regulation and stall report run
`timescale 1ns/1ns
`default_nettype none

module lacr_velocity_gate #(
	parameter int PERIOD_W = 20
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [PERIOD_W-1:0] i_step_period,
	input wire logic [PERIOD_W-1:0] i_lower_velocity_threshold,
	input wire logic [PERIOD_W-1:0] i_upper_velocity_threshold,
	output logic o_enable
);
	// Long period means slow motor: lower velocity bound is a period ceiling
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			o_enable <= 1'b0;
		else
			o_enable <= (i_step_period <= i_lower_velocity_threshold) &&
				(i_step_period >= i_upper_velocity_threshold);
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	property p_too_slow;
		i_step_period > i_lower_velocity_threshold |=> !o_enable;
	endproperty
	a_too_slow: assert property (p_too_slow)
		else $error("gate open below lower velocity");

	property p_too_fast;
		i_step_period < i_upper_velocity_threshold |=> !o_enable;
	endproperty
	a_too_fast: assert property (p_too_fast)
		else $error("gate open above upper velocity");
endmodule
`default_nettype wire

// >>> hw/lacr_regulator.sv
// Load-adaptive current regulator with register port and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "lacr_cfg.svh"

// How it works
// - Lower threshold is 4-bit field times 32, compared to 10-bit load.
// - Load below lower threshold raises the current scale of both coils.
// - Upper threshold is (lower + upper offset + 1) times 32.
// - Each low reading adds 1, 2, 4 or 8 to the scale.
// - One decrement per 32, 8, 2 or 1 readings at or above upper.
// - Minimum-current bit sets floor at half or quarter of run current.
// - Slower than the lower velocity threshold: regulation and stall off.
// - Faster than the upper velocity threshold: regulation and stall off.
// - Actual scale 0..31 is readable, bounded by run current and floor.
// - One load reading per full step drives one regulation decision.
// - Filter averages four readings, quartering the regulation rate.
module lacr_regulator #(
	parameter int PERIOD_W = 20
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_meas_valid,
	input wire lacr_pkg::lacr_load_t i_load_value,
	input wire logic [PERIOD_W-1:0] i_measured_step_period,
	output logic [31:0] o_rdata,
	output lacr_pkg::lacr_scale_t o_actual_current_scale,
	output logic o_stall,
	output logic o_irq
);
	if (PERIOD_W < 1 || PERIOD_W > 32) begin : g_bad_width
		$error("PERIOD_W must lie between 1 and 32");
	end

	// ======================================================================
	// Registers and decoded fields
	logic [31:0] config_reg;
	logic [PERIOD_W-1:0] vel_low_reg;
	logic [PERIOD_W-1:0] vel_high_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_stat_next;
	logic [2:0] irq_mask_reg;
	lacr_pkg::lacr_scale_t scale_reg;
	lacr_pkg::lacr_scale_t scale_next;
	logic [5:0] dec_cnt_reg;
	logic [5:0] dec_cnt_next;
	logic stall_reg;
	logic stall_next;
	lacr_pkg::lacr_load_t last_load_reg;

	logic [3:0] lower_load_threshold;
	logic [3:0] upper_threshold_offset;
	lacr_pkg::lacr_inc_code_t current_increment_width;
	lacr_pkg::lacr_dec_code_t decrement_reading_count;
	logic minimum_current_select;
	logic filter_enable;
	lacr_pkg::lacr_scale_t run_current_setting;

	assign lower_load_threshold = config_reg[`LACR_LOWER_LSB +: 4];
	assign upper_threshold_offset = config_reg[`LACR_UPPER_LSB +: 4];
	assign current_increment_width =
		lacr_pkg::lacr_inc_code_t'(config_reg[`LACR_INC_LSB +: 2]);
	assign decrement_reading_count =
		lacr_pkg::lacr_dec_code_t'(config_reg[`LACR_DEC_LSB +: 2]);
	assign minimum_current_select = config_reg[`LACR_MIN_BIT];
	assign filter_enable = config_reg[`LACR_FILT_BIT];
	assign run_current_setting = config_reg[`LACR_RUN_LSB +: 5];

	// ======================================================================
	// Measurement path and velocity window
	logic f_valid;
	lacr_pkg::lacr_load_t f_load;
	logic gate_en;

	lacr_load_filter u_filter (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_filter_enable(filter_enable),
		.i_valid(i_meas_valid),
		.i_load(i_load_value),
		.o_valid(f_valid),
		.o_load(f_load)
	);

	lacr_velocity_gate #(
		.PERIOD_W(PERIOD_W)
	) u_gate (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_step_period(i_measured_step_period),
		.i_lower_velocity_threshold(vel_low_reg),
		.i_upper_velocity_threshold(vel_high_reg),
		.o_enable(gate_en)
	);

	// ======================================================================
	// Thresholds, step widths and floor
	lacr_pkg::lacr_load_t lower_thr;
	lacr_pkg::lacr_load_t upper_thr;
	logic [4:0] upper_sum;
	lacr_pkg::lacr_scale_t inc_step;
	logic [5:0] inc_sum;
	logic [5:0] dec_target;
	logic [5:0] run_plus_one;
	logic [5:0] floor_count;
	lacr_pkg::lacr_scale_t floor_scale;
	logic reg_on;
	logic below;
	logic above;

	assign lower_thr = {1'b0, lower_load_threshold, `LACR_THRESH_ZEROS};
	assign upper_sum = {1'b0, lower_load_threshold} +
		{1'b0, upper_threshold_offset} + 5'h01;
	assign upper_thr = {upper_sum, `LACR_THRESH_ZEROS};
	assign below = f_load < lower_thr;
	assign above = f_load >= upper_thr;
	assign inc_step = 5'h01 << current_increment_width;
	assign inc_sum = {1'b0, scale_reg} + {1'b0, inc_step};

	always_comb begin
		unique case (decrement_reading_count)
			lacr_pkg::lacr_dec_per_32: dec_target = `LACR_DEC_COUNT_0;
			lacr_pkg::lacr_dec_per_8: dec_target = `LACR_DEC_COUNT_1;
			lacr_pkg::lacr_dec_per_2: dec_target = `LACR_DEC_COUNT_2;
			lacr_pkg::lacr_dec_per_1: dec_target = `LACR_DEC_COUNT_3;
		endcase
	end

	// Scale n means (n+1)/32, so the fraction is taken of n+1
	assign run_plus_one = {1'b0, run_current_setting} + 6'h01;
	assign floor_count = minimum_current_select ?
		(run_plus_one >> 2) : (run_plus_one >> 1);
	assign floor_scale = (floor_count == 6'h00) ? 5'h00 :
		floor_count[4:0] - 5'h01;

	assign reg_on = gate_en && (lower_load_threshold != 4'h0);

	// ======================================================================
	// Regulation decision, one per delivered reading
	logic raise_evt;
	logic lower_evt;

	always_comb begin
		scale_next = scale_reg;
		dec_cnt_next = dec_cnt_reg;
		raise_evt = 1'b0;
		lower_evt = 1'b0;
		if (!reg_on) begin
			// Outside the window or switched off: plain run current
			scale_next = run_current_setting;
			dec_cnt_next = 6'h00;
		end else begin
			if (f_valid) begin
				if (below) begin
					scale_next = (inc_sum > {1'b0, run_current_setting}) ?
						run_current_setting : inc_sum[4:0];
					dec_cnt_next = 6'h00;
					raise_evt = 1'b1;
				end else if (above) begin
					if (dec_cnt_reg + 6'h01 >= dec_target) begin
						dec_cnt_next = 6'h00;
						scale_next = (scale_reg > floor_scale) ?
							scale_reg - 5'h01 : floor_scale;
						lower_evt = 1'b1;
					end else begin
						dec_cnt_next = dec_cnt_reg + 6'h01;
					end
				end else begin
					// A reading in the band restarts the decrement count
					dec_cnt_next = 6'h00;
				end
			end
			// Clamp again so that a new run or floor setting acts at once
			if (scale_next > run_current_setting)
				scale_next = run_current_setting;
			if (scale_next < floor_scale)
				scale_next = floor_scale;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			scale_reg <= `LACR_RST_SCALE;
			dec_cnt_reg <= 6'h00;
		end else begin
			scale_reg <= scale_next;
			dec_cnt_reg <= dec_cnt_next;
		end
	end

	// ======================================================================
	// Stall indication
	always_comb begin
		stall_next = stall_reg;
		if (!gate_en)
			stall_next = 1'b0;
		else if (f_valid)
			stall_next = (f_load == 10'h000);
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			stall_reg <= 1'b0;
			last_load_reg <= 10'h000;
		end else begin
			stall_reg <= stall_next;
			if (f_valid)
				last_load_reg <= f_load;
		end
	end

	// ======================================================================
	// Interrupt status: set beats a simultaneous write-one clear
	logic [2:0] irq_clear;
	logic [2:0] irq_set;

	assign irq_clear = (i_wr && i_addr == `LACR_ADDR_IRQ_STAT) ?
		i_wdata[2:0] : 3'h0;
	assign irq_set = {stall_next && !stall_reg, lower_evt, raise_evt};
	assign irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_set;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			irq_stat_reg <= `LACR_RST_IRQ;
			o_irq <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			o_irq <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// ======================================================================
	// Register writes
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			config_reg <= `LACR_RST_CONFIG;
			vel_low_reg <= '0;
			vel_high_reg <= '0;
			irq_mask_reg <= `LACR_RST_IRQ;
		end else if (i_wr) begin
			unique case (i_addr)
				`LACR_ADDR_CONFIG: config_reg <= i_wdata & `LACR_CONFIG_MASK;
				`LACR_ADDR_VEL_LOW: vel_low_reg <= i_wdata[PERIOD_W-1:0];
				`LACR_ADDR_VEL_HIGH: vel_high_reg <= i_wdata[PERIOD_W-1:0];
				`LACR_ADDR_IRQ_MASK: irq_mask_reg <= i_wdata[2:0];
				default: ;
			endcase
		end
	end

	// ======================================================================
	// Register reads: data valid only in the cycle after the strobe
	logic [31:0] status_word;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`LACR_ST_SCALE_LSB +: 5] = scale_reg;
		status_word[`LACR_ST_STALL_BIT] = stall_reg;
		status_word[`LACR_ST_ACTIVE_BIT] = reg_on;
		status_word[`LACR_ST_LOAD_LSB +: 10] = last_load_reg;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			unique case (i_addr)
				`LACR_ADDR_CONFIG: o_rdata <= config_reg;
				`LACR_ADDR_VEL_LOW: o_rdata <= 32'(vel_low_reg);
				`LACR_ADDR_VEL_HIGH: o_rdata <= 32'(vel_high_reg);
				`LACR_ADDR_STATUS: o_rdata <= status_word;
				`LACR_ADDR_IRQ_STAT: o_rdata <= {29'h0, irq_stat_reg};
				`LACR_ADDR_IRQ_MASK: o_rdata <= {29'h0, irq_mask_reg};
				default: o_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	assign o_actual_current_scale = scale_reg;
	assign o_stall = stall_reg;

	// ======================================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_low_reading;
		reg_on && f_valid && below && !i_wr;
	endsequence

	sequence s_high_reading_each;
		reg_on && f_valid && above && !i_wr && scale_reg > floor_scale &&
			decrement_reading_count == lacr_pkg::lacr_dec_per_1;
	endsequence

	property p_raise;
		s_low_reading |=> scale_reg > $past(scale_reg) ||
			scale_reg == $past(run_current_setting);
	endproperty
	a_raise: assert property (p_raise)
		else $error("low reading did not raise the scale");

	property p_inc_bound;
		s_low_reading |=> {1'b0, scale_reg} <=
			{1'b0, $past(scale_reg)} + 6'h08;
	endproperty
	a_inc_bound: assert property (p_inc_bound)
		else $error("scale rose by more than eight");

	property p_dec_each;
		s_high_reading_each |=> scale_reg == $past(scale_reg) - 5'h01;
	endproperty
	a_dec_each: assert property (p_dec_each)
		else $error("single-count decrement missing");

	property p_dec_hold;
		reg_on && f_valid && above && !i_wr && dec_cnt_reg < 6'h1f &&
			decrement_reading_count == lacr_pkg::lacr_dec_per_32
			|=> scale_reg == $past(scale_reg);
	endproperty
	a_dec_hold: assert property (p_dec_hold)
		else $error("scale lowered before 32 high readings");

	property p_ceiling;
		scale_reg <= $past(run_current_setting);
	endproperty
	a_ceiling: assert property (p_ceiling)
		else $error("scale above run current");

	property p_floor;
		$past(reg_on) |-> scale_reg >= $past(floor_scale);
	endproperty
	a_floor: assert property (p_floor)
		else $error("scale below minimum current");

	property p_off_at_zero;
		lower_load_threshold == 4'h0 |=>
			scale_reg == $past(run_current_setting);
	endproperty
	a_off_at_zero: assert property (p_off_at_zero)
		else $error("regulating with zero lower threshold");

	property p_window_closed;
		!gate_en |=> !o_stall && scale_reg == $past(run_current_setting);
	endproperty
	a_window_closed: assert property (p_window_closed)
		else $error("stall or regulation outside velocity window");

	property p_stall_flag;
		$rose(stall_reg) |-> irq_stat_reg[`LACR_IRQ_STALL];
	endproperty
	a_stall_flag: assert property (p_stall_flag)
		else $error("stall did not set its status bit");
endmodule
`default_nettype wire

// >>> verification/lacr_motion_ctrl.sv
// Motion controller model that stops stepping when a stall is flagged
`timescale 1ns/1ns
`default_nettype none

module lacr_motion_ctrl (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_stall,
	input wire logic i_resume,
	input wire logic i_step,
	output logic o_meas_valid,
	output logic o_stop
);
	logic stall_d_reg;

	// ==================================================================
	// Stop on stall
	// Only a fresh stall stops; a held stall must not undo a resume
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			stall_d_reg <= 1'b0;
			o_stop <= 1'b0;
		end else begin
			stall_d_reg <= i_stall;
			if (i_resume) begin
				o_stop <= 1'b0;
			end else if (i_stall && !stall_d_reg) begin
				o_stop <= 1'b1;
			end
		end
	end

	// No steps, hence no readings, while stopped
	assign o_meas_valid = i_step && !o_stop;
endmodule
`default_nettype wire

// >>> verification/lacr_regulator_tb.sv
// Self-checking bench of the load-adaptive current regulator
`timescale 1ns/1ns
`default_nettype none
`include "lacr_cfg.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end

module lacr_regulator_tb;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdv;
	logic [31:0] rdata;
	logic wr = 1'b0, rd = 1'b0, step = 1'b0, resume = 1'b0, meas_valid;
	lacr_pkg::lacr_load_t load = 10'h000;
	logic [19:0] period = 20'h00032;
	lacr_pkg::lacr_scale_t scale;
	logic stall, irq, stop;
	int fails = 0, cmp_count = 0, cycles = 0, r;
	int c_low = 0, c_up, c_inc, c_dec, c_filt = 0, c_run = 31, m_win = 1;
	int m_scale = 31, m_cnt = 0, m_stall = 0, m_n = 0, m_sum = 0, fl = 15;
	int filt_loads[7] = '{1023, 1023, 1023, 0, 0, 0, 400};

	always #25 i_clk = ~i_clk;

	lacr_regulator #(.PERIOD_W(20)) dut_u (.i_clk(i_clk), .i_reset(i_reset),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.i_meas_valid(meas_valid), .i_load_value(load),
		.i_measured_step_period(period), .o_rdata(rdata),
		.o_actual_current_scale(scale), .o_stall(stall), .o_irq(irq));

	lacr_motion_ctrl ctl_u (.i_clk(i_clk), .i_reset(i_reset),
		.i_stall(stall), .i_resume(resume), .i_step(step),
		.o_meas_valid(meas_valid), .o_stop(stop));

	// ==================================================================
	// Bus tasks
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask

	task rd_reg(input logic [7:0] a);
		@(posedge i_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1 rdv = rdata;
	endtask

	// ==================================================================
	// Reference model
	function void clamp();
		if (m_scale > c_run) m_scale = c_run;
		if (m_scale < fl) m_scale = fl;
	endfunction

	task decide(input int ld_in);
		int ld, dn;
		ld = ld_in;
		dn = c_dec == 0 ? 32 : c_dec == 1 ? 8 : c_dec == 2 ? 2 : 1;
		if (c_filt != 0) begin
			m_sum += ld;
			m_n++;
			if (m_n < 4) return;
			ld = m_sum >> 2;
			m_sum = 0;
			m_n = 0;
		end
		m_stall = (m_win != 0 && ld == 0);
		if (m_win == 0 || c_low == 0) begin
			m_scale = c_run;
			m_cnt = 0;
			return;
		end
		if (ld < c_low * 32) begin
			m_scale += 1 << c_inc;
			m_cnt = 0;
		end else if (ld >= (c_low + c_up + 1) * 32) begin
			m_cnt++;
			if (m_cnt >= dn) begin
				m_cnt = 0;
				if (m_scale > fl) m_scale--;
			end
		end else begin
			m_cnt = 0;
		end
		clamp();
	endtask

	// Extra resume cycle keeps a stop from the last reading out of the way
	task meas(input int ld);
		@(posedge i_clk);
		resume <= 1'b1;
		@(posedge i_clk);
		resume <= 1'b0;
		step <= 1'b1;
		load <= ld[9:0];
		@(posedge i_clk);
		step <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		decide(ld);
		`CHK("scale", m_scale, scale)
		`CHK("stall", m_stall, stall)
	endtask

	// In-band settle reading clears the decrement count after a change
	task cfg(input int low, up, inc, dec, mn, filt, run, per);
		@(posedge i_clk);
		period <= per[19:0];
		wr_reg(`LACR_ADDR_CONFIG, {11'h000, run[4:0], 2'h0, filt[0], mn[0],
			dec[1:0], inc[1:0], up[3:0], low[3:0]});
		c_low = low;
		c_up = up;
		c_inc = inc;
		c_dec = dec;
		c_filt = filt;
		c_run = run;
		m_win = (per <= 100 && per >= 10);
		fl = ((run + 1) >> (mn != 0 ? 2 : 1)) - 1;
		if (fl < 0) fl = 0;
		if (m_win == 0) m_stall = 0;
		if (m_win == 0 || low == 0) m_scale = run;
		else clamp();
		if (filt == 0) begin
			m_n = 0;
			m_sum = 0;
		end
		meas(low * 32);
	endtask

	// ==================================================================
	// Verdict and watchdog
	task end_of_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	// ==================================================================
	// Main sequence
	initial begin
		r = $urandom(32'hea1c10aa);
		repeat (8) @(posedge i_clk);
		i_reset <= 1'b0;
		rd_reg(`LACR_ADDR_CONFIG);
		`CHK("config", `LACR_RST_CONFIG, rdv)
		rd_reg(`LACR_ADDR_STATUS);
		`CHK("status", 31, rdv[4:0])
		rd_reg(`LACR_ADDR_IRQ_MASK);
		`CHK("mask", 0, rdv)
		@(posedge i_clk);
		#1;
		`CHK("rd idle", 0, rdata)
		rd_reg(8'h18);
		`CHK("unmapped", 0, rdv)
		wr_reg(`LACR_ADDR_CONFIG, 32'hffff_ffff);
		rd_reg(`LACR_ADDR_CONFIG);
		`CHK("cfg mask", `LACR_CONFIG_MASK, rdv)
		wr_reg(`LACR_ADDR_VEL_LOW, 32'd100);
		wr_reg(`LACR_ADDR_VEL_HIGH, 32'd10);
		rd_reg(`LACR_ADDR_VEL_LOW);
		`CHK("vel low", 100, rdv)
		rd_reg(`LACR_ADDR_VEL_HIGH);
		`CHK("vel high", 10, rdv)
		// Random loads over every code, window edge and a disabled case
		for (int k = 0; k < 8; k++) begin
			cfg(k == 3 ? 0 : 1 + $urandom % 15, $urandom % 16, k % 4,
				(k + 1) % 4, k % 2, 0, 16 + $urandom % 16,
				k == 1 ? 200 : k == 2 ? 5 : k == 4 ? 100 : k == 5 ? 10 : 50);
			repeat (60) begin
				r = $urandom % 4;
				meas(r == 0 ? $urandom % (c_low * 32 + 1) : 1023 - $urandom % 300);
			end
		end
		// Averaging over groups of four
		cfg(4, 2, 0, 3, 0, 0, 31, 50);
		cfg(4, 2, 0, 3, 0, 1, 31, 50);
		foreach (filt_loads[i]) meas(filt_loads[i]);
		// Interrupt: raise, mask, clear, stall
		cfg(4, 0, 3, 3, 0, 0, 31, 50);
		meas(64);
		wr_reg(`LACR_ADDR_IRQ_STAT, 32'h7);
		rd_reg(`LACR_ADDR_IRQ_STAT);
		`CHK("irq clr", 0, rdv)
		meas(1023);
		rd_reg(`LACR_ADDR_IRQ_STAT);
		`CHK("irq low", 3'h2, rdv[2:0])
		`CHK("irq off", 1'b0, irq)
		wr_reg(`LACR_ADDR_IRQ_MASK, 32'h2);
		@(posedge i_clk);
		#1;
		`CHK("irq on", 1'b1, irq)
		wr_reg(`LACR_ADDR_IRQ_STAT, 32'h2);
		@(posedge i_clk);
		#1;
		`CHK("irq w1c", 1'b0, irq)
		meas(0);
		rd_reg(`LACR_ADDR_STATUS);
		`CHK("st scale", m_scale, rdv[4:0])
		`CHK("st stall", 1'b1, rdv[5])
		`CHK("st active", 1'b1, rdv[6])
		`CHK("st load", 0, rdv[25:16])
		rd_reg(`LACR_ADDR_IRQ_STAT);
		`CHK("irq stall", 1'b1, rdv[2])
		`CHK("stop", 1'b1, stop)
		end_of_test();
	end
endmodule
`default_nettype wire
